// [hdl/mode_bus_pkg.sv]
// Package: mode decode, register map and bus timing constants
package mode_bus_pkg;
   // ===========================================================
   // Register map (plain port, byte offsets)
   localparam logic [3:0] off_area_wait_control_low = 4'h0;
   localparam logic [3:0] off_access_state_control  = 4'h1;
   localparam logic [3:0] off_area_width_control    = 4'h2;
   localparam logic [3:0] off_mode_status           = 4'h3;
   // ===========================================================
   // Field positions and reset values
   localparam int area3_wait_bit1_pos = 7;
   localparam int area3_wait_bit0_pos = 6;
   localparam int area3_three_state_pos = 3;
   localparam logic [7:0] area_wait_control_low_rst = 8'hff;
   localparam logic [7:0] access_state_control_rst  = 8'hff;
   localparam int num_areas = 8;
   // ===========================================================
   // Mode pin patterns
   localparam logic [2:0] mode4_pins = 3'h4;
   localparam logic [2:0] mode5_pins = 3'h5;
   localparam logic [2:0] mode6_pins = 3'h6;
   localparam logic [2:0] mode7_pins = 3'h7;
   localparam logic [3:0] first_area3_wait = 4'h0;
   localparam logic [1:0] t_last_fixed = 2'h2;
   // ===========================================================
   // External cycle states, Gray ordered along the three-state path without waits
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_t1   = 3'b001,
      st_t2   = 3'b011,
      st_t3   = 3'b010,
      st_tw   = 3'b111
   } ext_state_t;
   localparam int unused_pad = 0;
endpackage

// [hdl/mode_cfg_if.sv]
// Interface: latched mode configuration shared with the cycle sequencer
`timescale 1ns/1ps
interface mode_cfg_if;
   logic       ext_enable;
   logic       bus16;
   logic [1:0] area3_waits;
   logic       area3_three_state;
   modport cfg (output ext_enable, output bus16, output area3_waits, output area3_three_state);
   modport seq (input ext_enable, input bus16, input area3_waits, input area3_three_state);
endinterface

// [hdl/ext_cycle_seq.sv]
// External access cycle sequencer for area 3 with program waits
`timescale 1ns/1ps
module ext_cycle_seq (
   input  wire logic ref_clk,
   input  wire logic rstn,
   mode_cfg_if.seq   cfg,
   input  wire logic start,
   output logic      busy,
   output logic      wait_state,
   output logic      done
);
   mode_bus_pkg::ext_state_t state;
   mode_bus_pkg::ext_state_t next_state;
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;
   logic       go;
   logic       waits_due;
   assign go        = start && cfg.ext_enable;
   assign waits_due = cfg.area3_three_state && (cfg.area3_waits != 2'h0);

   // ===========================================================
   // State sequencing
   always_comb begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      case (state)
         mode_bus_pkg::st_idle: begin
            if (go) next_state = mode_bus_pkg::st_t1;
         end
         mode_bus_pkg::st_t1: begin
            next_state = mode_bus_pkg::st_t2;
         end
         mode_bus_pkg::st_t2: begin
            // Waits go between second and third state
            if (waits_due) begin // R10
               next_state    = mode_bus_pkg::st_tw;
               next_wait_cnt = cfg.area3_waits; // R9
            end else if (cfg.area3_three_state) begin
               next_state = mode_bus_pkg::st_t3; // R10
            end else begin
               next_state = mode_bus_pkg::st_idle;
            end
         end
         mode_bus_pkg::st_tw: begin
            if (wait_cnt == 2'h1) next_state = mode_bus_pkg::st_t3; // R10
            next_wait_cnt = wait_cnt - 2'h1;
         end
         mode_bus_pkg::st_t3: begin
            next_state = mode_bus_pkg::st_idle;
         end
         default: begin
            next_state = mode_bus_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state    <= mode_bus_pkg::st_idle;
         wait_cnt <= 2'h0;
      end else begin
         state    <= next_state;
         wait_cnt <= next_wait_cnt;
      end
   end

   assign busy       = (state != mode_bus_pkg::st_idle);
   assign wait_state = (state == mode_bus_pkg::st_tw);
   assign done       = busy && (next_state == mode_bus_pkg::st_idle);
endmodule

// [hdl/mode_select_bus_config.sv]
// Top: mode decode, bus width selection, wait control registers
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1 - Mode pins 100..111 select modes 4 through 7
// R2 - Modes 4, 5 and 6 allow external memory and peripheral access
// R3 - Mode 7 is single-chip, ROM on, no external space
// R4 - ROM disabled in modes 4 and 5, enabled in 6 and 7
// R5 - Initial bus width 16 bits in mode 4, 8 bits in 5 and 6
// R6 - Bus is 16-bit if any area is 16-bit, else 8-bit
// R7 - Outside holds mode pins steady while operating
// R8 - Word and longword accesses force address bit 0 to zero
// R9 - Area 3 wait field bits 7:6, reset 11, gives 0..3 waits
// R10 - Program waits inserted between second and third access states
// R11 - Mode pins sampled during reset and held until next reset
module mode_select_bus_config (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        mode_pin_2,
   input  wire logic        mode_pin_1,
   input  wire logic        mode_pin_0,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [23:0] cpu_addr,
   input  wire logic        cpu_wide,
   input  wire logic        ext_start,
   output logic      [23:0] ext_addr,
   output logic             ext_busy,
   output logic             ext_wait,
   output logic             ext_done,
   output logic             rom_enable,
   output logic             ext_enable,
   output logic             bus16,
   output logic      [2:0]  op_mode
);
   logic [2:0] mode_pins;
   logic [2:0] mode_latched;
   logic       mode_valid;
   logic [7:0] area_wait_control_low;
   logic [7:0] access_state_control;
   logic [7:0] area_width_control;
   logic [7:0] next_width_init;
   logic [7:0] mode_status;
   logic [7:0] next_rdata;
   logic       sel_wait;
   logic       sel_ast;
   logic       sel_width;
   logic       sel_status;
   mode_cfg_if cfg_bus ();

   // ===========================================================
   // Mode capture while reset is held
   assign mode_pins = {mode_pin_2, mode_pin_1, mode_pin_0};
   always_ff @(posedge ref_clk) begin
      if (!rstn) mode_latched <= mode_pins; // R11 R7
   end
   assign mode_valid = mode_latched[2]; // R1
   assign op_mode    = mode_valid ? mode_latched : mode_bus_pkg::mode7_pins; // R1
   assign ext_enable = (op_mode != mode_bus_pkg::mode7_pins); // R2 R3
   assign rom_enable = (op_mode == mode_bus_pkg::mode6_pins) || (op_mode == mode_bus_pkg::mode7_pins); // R4 R3

   // ===========================================================
   // Initial widths by mode
   assign next_width_init = (mode_pins == mode_bus_pkg::mode4_pins) ? 8'hff : 8'h00; // R5

   // ===========================================================
   // Register decode
   assign sel_wait   = (reg_addr == mode_bus_pkg::off_area_wait_control_low);
   assign sel_ast    = (reg_addr == mode_bus_pkg::off_access_state_control);
   assign sel_width  = (reg_addr == mode_bus_pkg::off_area_width_control);
   assign sel_status = (reg_addr == mode_bus_pkg::off_mode_status);
   assign mode_status = {3'h0, rom_enable, ext_enable, bus16, op_mode[1:0]};

   always_comb begin
      if (sel_wait) next_rdata = area_wait_control_low;
      else if (sel_ast) next_rdata = access_state_control;
      else if (sel_width) next_rdata = area_width_control;
      else if (sel_status) next_rdata = mode_status;
      else next_rdata = 8'h00;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         area_wait_control_low <= mode_bus_pkg::area_wait_control_low_rst; // R9
         access_state_control  <= mode_bus_pkg::access_state_control_rst;
         area_width_control    <= next_width_init; // R5
      end else if (reg_wr) begin
         if (sel_wait) area_wait_control_low <= reg_wdata; // R9
         if (sel_ast) access_state_control <= reg_wdata;
         if (sel_width && ext_enable) area_width_control <= reg_wdata; // R6
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) reg_rdata <= 8'h00;
      else reg_rdata <= reg_rd ? next_rdata : 8'h00;
   end

   // ===========================================================
   // Bus width and address alignment
   assign bus16 = ext_enable && (|area_width_control); // R6

   always_ff @(posedge ref_clk) begin
      if (!rstn) ext_addr <= 24'h000000;
      else if (ext_start) ext_addr <= {cpu_addr[23:1], cpu_addr[0] & ~cpu_wide}; // R8
   end

   // ===========================================================
   // Configuration to cycle sequencer
   assign cfg_bus.ext_enable        = ext_enable;
   assign cfg_bus.bus16             = bus16;
   assign cfg_bus.area3_waits       = {area_wait_control_low[mode_bus_pkg::area3_wait_bit1_pos],
                                       area_wait_control_low[mode_bus_pkg::area3_wait_bit0_pos]}; // R9
   assign cfg_bus.area3_three_state = access_state_control[mode_bus_pkg::area3_three_state_pos];

   ext_cycle_seq u_seq (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .cfg        (cfg_bus.seq),
      .start      (ext_start),
      .busy       (ext_busy),
      .wait_state (ext_wait),
      .done       (ext_done)
   );

   // ===========================================================
   // Checks
   property p_mode7_no_ext;
      @(posedge ref_clk) disable iff (!rstn) (op_mode == 3'h7) |-> (!ext_enable && rom_enable && !bus16);
   endproperty
   a_mode7_no_ext: assert property (p_mode7_no_ext) else $error("Mode 7 allows external access"); // R3

   property p_rom_map;
      @(posedge ref_clk) disable iff (!rstn) rom_enable == op_mode[1];
   endproperty
   a_rom_map: assert property (p_rom_map) else $error("ROM enable wrong for mode"); // R4

   property p_ext_modes;
      @(posedge ref_clk) disable iff (!rstn) (op_mode inside {3'h4, 3'h5, 3'h6}) |-> ext_enable;
   endproperty
   a_ext_modes: assert property (p_ext_modes) else $error("Extended mode lacks external access"); // R2

   property p_mode_range;
      @(posedge ref_clk) disable iff (!rstn) op_mode[2];
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("Mode outside 4 to 7"); // R1

   property p_mode_fixed;
      @(posedge ref_clk) disable iff (!rstn) $stable(op_mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("Mode changed while running"); // R11

   property p_bus16_any;
      @(posedge ref_clk) disable iff (!rstn) ext_enable |-> (bus16 == (area_width_control != 8'h00));
   endproperty
   a_bus16_any: assert property (p_bus16_any) else $error("Bus mode disagrees with area widths"); // R6

   property p_align;
      @(posedge ref_clk) disable iff (!rstn) (ext_start && cpu_wide) |=> !ext_addr[0];
   endproperty
   a_align: assert property (p_align) else $error("Wide access kept odd address"); // R8

   property p_wait_reset;
      @(posedge ref_clk) $rose(rstn) |-> area_wait_control_low[7:6] == 2'h3;
   endproperty
   a_wait_reset: assert property (p_wait_reset) else $error("Area 3 wait field not 11 after reset"); // R9

   property p_wait_len;
      @(posedge ref_clk) disable iff (!rstn)
         ($rose(ext_wait) && cfg_bus.area3_waits == 2'h3) |-> ext_wait [*3] ##1 !ext_wait;
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("Three waits not inserted"); // R10

   property p_init_width;
      @(posedge ref_clk) $rose(rstn) |-> bus16 == (op_mode == 3'h4);
   endproperty
   a_init_width: assert property (p_init_width) else $error("Initial bus width wrong"); // R5

   property p_t3_after_wait;
      @(posedge ref_clk) disable iff (!rstn) $fell(ext_wait) |-> (ext_busy && ext_done);
   endproperty
   a_t3_after_wait: assert property (p_t3_after_wait) else $error("No third state after waits"); // R10

   property p_mode7_width_locked;
      @(posedge ref_clk) disable iff (!rstn) !ext_enable |=> $stable(area_width_control);
   endproperty
   a_mode7_width_locked: assert property (p_mode7_width_locked) else $error("Width changed in single-chip"); // R3
endmodule

// [tb/ext_mem_model.sv]
// Partner model: external area-3 device that times each access cycle
`timescale 1ns/1ps
module ext_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        ext_busy,
   input  wire logic        ext_wait,
   input  wire logic        ext_done,
   input  wire logic [23:0] ext_addr,
   output logic             cyc_seen,
   output logic      [31:0] cyc_rec
);
   int len   = 0;
   int waits = 0;
   initial cyc_seen = 1'b0;
   // ===========================================================
   // Count busy and wait states, report length and address at the last state
   always @(posedge ref_clk) begin
      cyc_seen <= 1'b0;
      if (ext_busy) begin
         len = len + 1;
         if (ext_wait) waits = waits + 1;
         if (ext_done) begin
            cyc_rec  <= {len[3:0], waits[3:0], ext_addr};
            cyc_seen <= 1'b1;
            len = 0;
            waits = 0;
         end
      end
   end
endmodule

// [tb/tb_top.sv]
// Testbench: mode decode, width, wait registers and area-3 cycles
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk, rstn, mode_pin_2, mode_pin_1, mode_pin_0;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, cpu_wide, ext_start;
   logic [23:0] cpu_addr, ext_addr;
   logic        ext_busy, ext_wait, ext_done, rom_enable, ext_enable, bus16;
   logic [2:0]  op_mode;
   logic        cyc_seen;
   logic [31:0] cyc_rec;
   logic        rd_pend = 1'b0;
   logic [31:0] rd_q[$];
   logic [31:0] cyc_q[$];
   int          fails = 0;
   int          check_count = 0;
   int          cycles = 0;

   mode_select_bus_config DUT (.ref_clk(ref_clk), .rstn(rstn), .mode_pin_2(mode_pin_2), .mode_pin_1(mode_pin_1),
      .mode_pin_0(mode_pin_0), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_wide(cpu_wide), .ext_start(ext_start), .ext_addr(ext_addr),
      .ext_busy(ext_busy), .ext_wait(ext_wait), .ext_done(ext_done), .rom_enable(rom_enable),
      .ext_enable(ext_enable), .bus16(bus16), .op_mode(op_mode));
   ext_mem_model partner (.ref_clk(ref_clk), .ext_busy(ext_busy), .ext_wait(ext_wait), .ext_done(ext_done),
      .ext_addr(ext_addr), .cyc_seen(cyc_seen), .cyc_rec(cyc_rec));

   // ===========================================================
   // Clock, timeout and result watcher
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         close_out();
      end
   end
   always @(posedge ref_clk) begin
      if (rd_pend) chk(reg_rdata, rd_q.pop_front());
      rd_pend <= reg_rd;
      if (cyc_seen) chk(cyc_rec, cyc_q.pop_front());
   end

   // ===========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (rd_q.size() != 0 || cyc_q.size() != 0) fails++;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] p);
      @(posedge ref_clk);
      rstn <= 1'b0;
      {mode_pin_2, mode_pin_1, mode_pin_0} <= p;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(negedge ref_clk);
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
      rd_q.push_back({24'h0, exp});
      @(posedge ref_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic ext_cycle(input logic [23:0] a, input logic wide, input logic [3:0] w, input logic three);
      cyc_q.push_back({three ? w + 4'h3 : 4'h2, w, a[23:1], a[0] & ~wide});
      @(posedge ref_clk);
      {ext_start, cpu_addr, cpu_wide} <= {1'b1, a, wide};
      @(posedge ref_clk);
      ext_start <= 1'b0;
      for (int i = 0; i < 20 && ext_done !== 1'b1; i++) @(negedge ref_clk);
      if (ext_done !== 1'b1) fails++;
      @(posedge ref_clk);
   endtask

   // ===========================================================
   // Main sequence
   initial begin
      int m;
      {rstn, mode_pin_2, mode_pin_1, mode_pin_0, reg_addr, reg_wdata} = '0;
      {reg_wr, reg_rd, cpu_addr, cpu_wide, ext_start} = '0;
      void'($urandom(94120));
      for (m = 4; m < 8; m++) begin
         do_reset(m[2:0]);
         chk(op_mode, m);
         chk(ext_enable, m != 7);
         chk(rom_enable, m > 5);
         if (m < 7) reg_read(mode_bus_pkg::off_mode_status, {3'h0, m > 5, 1'b1, m == 4, m[1:0]});
         reg_read(mode_bus_pkg::off_area_wait_control_low, mode_bus_pkg::area_wait_control_low_rst);
         if (m == 7) begin
            reg_write(mode_bus_pkg::off_area_width_control, 8'hff);
            reg_read(mode_bus_pkg::off_area_width_control, 8'h00);
            chk(bus16, 1'b0);
         end
      end
      @(posedge ref_clk);
      ext_start <= 1'b1;
      mode_pin_1 <= 1'b0;
      @(posedge ref_clk);
      ext_start <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(ext_busy, 1'b0);
      chk(op_mode, 3'h7);
      do_reset(3'h5);
      reg_write(mode_bus_pkg::off_area_width_control, 8'h00);
      @(negedge ref_clk);
      chk(bus16, 1'b0);
      reg_write(mode_bus_pkg::off_area_width_control, 8'h01 << ($urandom % 8));
      @(negedge ref_clk);
      chk(bus16, 1'b1);
      reg_read(4'h5, 8'h00);
      for (m = 0; m < 4; m++) begin
         reg_write(mode_bus_pkg::off_area_wait_control_low, {m[1:0], 6'h3f});
         reg_read(mode_bus_pkg::off_area_wait_control_low, {m[1:0], 6'h3f});
         ext_cycle(24'($urandom), 1'($urandom % 2), m[3:0], 1'b1);
      end
      reg_write(mode_bus_pkg::off_access_state_control, 8'hf7);
      reg_read(mode_bus_pkg::off_access_state_control, 8'hf7);
      ext_cycle(24'($urandom), 1'b1, 4'h0, 1'b0);
      repeat (4) @(posedge ref_clk);
      close_out();
   end
endmodule
